// ==== core/oneshot_pulse_timer.sv ====
// Down-counting timer in programmable one-shot mode with its register port.
// Assumes all inputs are synchronous to clk and a companion timer that
// delivers one-cycle underflow pulses on companion_underflow.
//
// Overview of operation
// - One pulse per trigger; secondary count unused.
// - Count clock from div1, div2, div8, companion.
// - Prescaler and primary counter decrement when running.
// - Underflow reloads counters and clears active flag on the same edge.
// - Any stop reloads counters before halting.
// - Pulse lasts (n+1)(m+1) count clock periods.
// - Triggers ignored while count enable is zero.
// - Trigger from start bit or pin edge.
// - Counting stops after underflow reload completes.
// - Writing one-shot stop ends pulse.
// - Clearing count enable stops counting.
// - Force stop halts counting immediately.
// - Interrupt request coincides with pulse end.
// - Pin triggers only when pin trigger enabled.
// - Count reads return live counter values.
// - Stopped writes load reload and counter.
// - Running writes load reload register only.
// - Output polarity follows output level select.
// - Level zero: high pulse, low idle.
// - Active flag set after trigger; no retrigger.
// - Polarity bit selects falling or rising edge.

`include "oneshot_timer_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module oneshot_pulse_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic ext_trigger_pin,
  input wire logic companion_underflow,
  output logic [7:0] rdata,
  output logic pulse_out_pin,
  output logic timer_irq
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic count_enable_bit, output_level_select, output_source_select;
  logic pin_trigger_enable, pin_trigger_polarity;
  oneshot_timer_pkg::count_source_e source_sel;
  logic [7:0] prescale_reload, primary_reload, secondary_count_reg;
  logic [7:0] prescale_cnt, primary_cnt;
  oneshot_timer_pkg::run_state_e state, next_state;
  logic [2:0] div_cnt;
  logic pin_prev;

  logic wr_ctrl, wr_osc, wr_pre, wr_prim;
  logic tick, pin_edge, trigger, stop_req, underflow, running;

  assign wr_ctrl = wr && (addr == `TIMER_CONTROL_REG);
  assign wr_osc = wr && (addr == `ONESHOT_CONTROL_REG);
  assign wr_pre = wr && (addr == `PRESCALE_COUNT_REG);
  assign wr_prim = wr && (addr == `PRIMARY_COUNT_REG);
  assign running = (state == oneshot_timer_pkg::PULSE);

  // --------------------------------------------------------------------
  // Count source
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      div_cnt <= 3'h0;
    else
      div_cnt <= div_cnt + 3'h1;
  end

  always_comb
  begin
    case (source_sel)
      oneshot_timer_pkg::SRC_DIV1: tick = 1'b1;
      oneshot_timer_pkg::SRC_DIV2: tick = div_cnt[0];
      oneshot_timer_pkg::SRC_DIV8: tick = (div_cnt == `DIV8_LAST);
      default: tick = companion_underflow;
    endcase
  end

  // --------------------------------------------------------------------
  // Trigger and stop decode
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pin_prev <= 1'b0;
    else
      pin_prev <= ext_trigger_pin;
  end

  assign pin_edge = pin_trigger_enable &&
    (pin_trigger_polarity ? (ext_trigger_pin && !pin_prev)
                          : (!ext_trigger_pin && pin_prev));

  assign trigger = pin_edge ||
    (wr_osc && wdata[`ONESHOT_START_BIT]);

  assign stop_req =
    (wr_ctrl && (!wdata[`COUNT_ENABLE_BIT] || wdata[`FORCE_STOP_BIT])) ||
    (wr_osc && wdata[`ONESHOT_STOP_BIT]);

  assign underflow = (prescale_cnt == 8'h00) && (primary_cnt == 8'h00);

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count_enable_bit <= 1'b0;
    else if (wr_ctrl)
      count_enable_bit <= wdata[`COUNT_ENABLE_BIT] && !wdata[`FORCE_STOP_BIT];
  end

  // Output source select is stored only; the pin always carries the timer
  // waveform, so a wrong setting by software cannot corrupt the pulse.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {pin_trigger_polarity, pin_trigger_enable,
       output_source_select, output_level_select} <= `IO_CONTROL_RESET;
    end
    else if (wr && addr == `IO_CONTROL_REG)
    begin
      output_level_select <= wdata[`OUTPUT_LEVEL_SELECT];
      output_source_select <= wdata[`OUTPUT_SOURCE_SELECT];
      pin_trigger_enable <= wdata[`PIN_TRIGGER_ENABLE];
      pin_trigger_polarity <= wdata[`PIN_TRIGGER_POLARITY];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      source_sel <= oneshot_timer_pkg::SRC_DIV1;
    else if (wr && addr == `SOURCE_SELECT_REG)
      source_sel <= oneshot_timer_pkg::count_source_e'(wdata[1:0]);
  end

  // secondary count kept for software only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      secondary_count_reg <= `COUNT_RESET;
    else if (wr && addr == `SECONDARY_COUNT_REG)
      secondary_count_reg <= wdata;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prescale_reload <= `COUNT_RESET;
      primary_reload <= `COUNT_RESET;
    end
    else
    begin
      if (wr_pre)
        prescale_reload <= wdata;
      if (wr_prim)
        primary_reload <= wdata;
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    if (stop_req)
      next_state = oneshot_timer_pkg::IDLE;
    else
    begin
      case (state)
        oneshot_timer_pkg::IDLE:
          if (trigger && count_enable_bit)
            next_state = oneshot_timer_pkg::ARMED;
        // flag rises at next count clock
        oneshot_timer_pkg::ARMED:
          if (tick)
            next_state = oneshot_timer_pkg::PULSE;
        oneshot_timer_pkg::PULSE:
          if (tick && underflow)
            next_state = oneshot_timer_pkg::IDLE;
        default:
          next_state = oneshot_timer_pkg::IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state <= oneshot_timer_pkg::IDLE;
    else
      state <= next_state;
  end

  // --------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------
  // Stopped counters track the reload registers, so every stop reloads and
  // a stopped write lands in both copies in the same cycle.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prescale_cnt <= `COUNT_RESET;
      primary_cnt <= `COUNT_RESET;
    end
    else if (!running || stop_req)
    begin
      prescale_cnt <= wr_pre ? wdata : prescale_reload;
      primary_cnt <= wr_prim ? wdata : primary_reload;
    end
    else if (tick)
    begin
      if (underflow)
      begin
        prescale_cnt <= prescale_reload;
        primary_cnt <= primary_reload;
      end
      else if (prescale_cnt == 8'h00)
      begin
        prescale_cnt <= prescale_reload;
        primary_cnt <= primary_cnt - 8'h01;
      end
      else
        prescale_cnt <= prescale_cnt - 8'h01;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // The interrupt cannot lag by half a count clock at div1, so it is issued
  // on the same edge that ends the pulse.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pulse_out_pin <= 1'b0;
      timer_irq <= 1'b0;
    end
    else
    begin
      pulse_out_pin <= (next_state == oneshot_timer_pkg::PULSE) ^
        output_level_select;
      timer_irq <= running && tick && underflow && !stop_req;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `TIMER_CONTROL_REG:
          rdata <= {6'h00, running, count_enable_bit};
        `ONESHOT_CONTROL_REG:
          rdata <= {5'h00, running, 2'h0};
        `IO_CONTROL_REG:
          rdata <= {4'h0, pin_trigger_polarity, pin_trigger_enable,
                    output_source_select, output_level_select};
        `PRESCALE_COUNT_REG: rdata <= prescale_cnt;
        `PRIMARY_COUNT_REG: rdata <= primary_cnt;
        `SECONDARY_COUNT_REG: rdata <= secondary_count_reg;
        `SOURCE_SELECT_REG: rdata <= {6'h00, source_sel};
        default: rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking chk_clk @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence tick_in_pulse;
    running && tick && !stop_req;
  endsequence
  sequence idle_enabled_start;
    state == oneshot_timer_pkg::IDLE && count_enable_bit && trigger &&
      !stop_req;
  endsequence

  idle_level_a: assert property (
    state == oneshot_timer_pkg::IDLE && $past(next_state) ==
      oneshot_timer_pkg::IDLE |-> pulse_out_pin == $past(output_level_select))
    else $error("pin not at idle level");
  trigger_ignored_a: assert property (
    state == oneshot_timer_pkg::IDLE && !count_enable_bit
      |=> state == oneshot_timer_pkg::IDLE)
    else $error("trigger accepted while disabled");
  start_arms_a: assert property (
    idle_enabled_start |=> state == oneshot_timer_pkg::ARMED)
    else $error("trigger did not arm");
  flag_rise_a: assert property (
    state == oneshot_timer_pkg::ARMED && tick && !stop_req
      |=> running ##0 pulse_out_pin != output_level_select)
    else $error("active flag not set on count clock");
  no_retrigger_a: assert property (
    tick_in_pulse and !underflow |=> running)
    else $error("pulse cut short or retriggered");
  prescale_step_a: assert property (
    tick_in_pulse and prescale_cnt != 8'h00
      |=> prescale_cnt == $past(prescale_cnt) - 8'h01 &&
          primary_cnt == $past(primary_cnt))
    else $error("prescaler did not decrement");
  underflow_end_a: assert property (
    tick_in_pulse and underflow |=> !running && timer_irq &&
      primary_cnt == $past(primary_reload) &&
      prescale_cnt == $past(prescale_reload))
    else $error("underflow did not reload and stop");
  stop_reload_a: assert property (
    stop_req |=> state == oneshot_timer_pkg::IDLE &&
      primary_cnt == $past(primary_reload) && !timer_irq)
    else $error("stop without reload");
  running_write_a: assert property (
    running && wr_prim && !tick && !stop_req
      |=> primary_cnt == $past(primary_cnt) && primary_reload == $past(wdata))
    else $error("running write reached counter");
  stopped_write_a: assert property (
    !running && wr_pre |=> prescale_cnt == $past(wdata))
    else $error("stopped write missed counter");
  live_read_a: assert property (
    rd && addr == `PRIMARY_COUNT_REG |=> rdata == $past(primary_cnt))
    else $error("count read not live");
  irq_with_end_a: assert property (
    timer_irq |-> !running && pulse_out_pin == $past(output_level_select))
    else $error("request not at pulse end");

endmodule

`default_nettype wire

// ==== core/oneshot_timer_pkg.sv ====
// Types shared by the one-shot timer design.
// Assumes nothing of its surroundings.
package oneshot_timer_pkg;

  typedef enum logic [1:0] {
    SRC_DIV1,
    SRC_DIV2,
    SRC_DIV8,
    SRC_COMPANION
  } count_source_e;

  typedef enum logic [1:0] {
    IDLE,
    ARMED,
    PULSE
  } run_state_e;

endpackage

// ==== core/oneshot_timer_regs.svh ====
// Register offsets, field positions and reset values of the one-shot timer.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef ONESHOT_TIMER_REGS_SVH
`define ONESHOT_TIMER_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define TIMER_CONTROL_REG 4'h0
`define ONESHOT_CONTROL_REG 4'h1
`define IO_CONTROL_REG 4'h2
`define PRESCALE_COUNT_REG 4'h3
`define PRIMARY_COUNT_REG 4'h4
`define SECONDARY_COUNT_REG 4'h5
`define SOURCE_SELECT_REG 4'h6

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define COUNT_ENABLE_BIT 0
`define COUNT_STATUS_BIT 1
`define FORCE_STOP_BIT 2
`define ONESHOT_START_BIT 0
`define ONESHOT_STOP_BIT 1
`define ONESHOT_ACTIVE_FLAG 2
`define OUTPUT_LEVEL_SELECT 0
`define OUTPUT_SOURCE_SELECT 1
`define PIN_TRIGGER_ENABLE 2
`define PIN_TRIGGER_POLARITY 3

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define COUNT_RESET 8'hFF
`define IO_CONTROL_RESET 4'h0
`define DIV8_LAST 3'h7

`endif

// ==== verif/oneshot_pulse_timer_test.sv ====
// Self-checking bench for the one-shot timer and its register port.
// Assumes the register map header and the far-side model pulse_load.
`include "oneshot_timer_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module oneshot_pulse_timer_test;
  localparam logic [3:0] tc_reg = `TIMER_CONTROL_REG;
  localparam logic [3:0] osc_reg = `ONESHOT_CONTROL_REG;
  localparam logic [3:0] pri_reg = `PRIMARY_COUNT_REG;
  logic clk, resetn, wr, rd, companion_underflow, fire, level;
  logic prev_out = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  logic pulse_out_pin, timer_irq, ext_trigger_pin;
  logic [1:0] tick = 2'h0;
  int errors = 0;
  int cmp_count = 0;
  int irq_cnt = 0;
  int pulse_cnt, width, base, ib, d;

  oneshot_pulse_timer dut (.clk, .resetn, .addr, .wdata, .wr, .rd,
    .ext_trigger_pin, .companion_underflow, .rdata, .pulse_out_pin,
    .timer_irq);
  pulse_load far (.clk, .fire, .level, .pulse_out_pin, .ext_trigger_pin,
    .pulse_cnt, .width);

  // ------------------------------------------------------------------
  // Clock, companion ticks and shared tasks
  // ------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    tick <= tick + 2'h1;
    companion_underflow <= (tick == 2'h3);
    if (timer_irq === 1'b1)
    begin
      irq_cnt <= irq_cnt + 1;
      check(pulse_out_pin === level && prev_out !== level, 1'b1);
    end
    prev_out <= pulse_out_pin;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic wait_pulse();
    for (int i = 0; i < 3000 && pulse_cnt == base; i++)
      @(posedge clk);
    if (pulse_cnt == base)
    begin
      errors++;
      complete_run();
    end
  endtask

  // stopped setup, source bit kept 0
  task automatic prog(input logic [7:0] s, n, m, io);
    wr_reg(tc_reg, 8'h00);
    wr_reg(`IO_CONTROL_REG, io);
    wr_reg(`SOURCE_SELECT_REG, s);
    wr_reg(`PRESCALE_COUNT_REG, n);
    wr_reg(pri_reg, m);
    wr_reg(tc_reg, 8'h01);
    cycles(2);
    base = pulse_cnt;
    ib = irq_cnt;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // widths per source
  task automatic t_width();
    int nn[4] = '{0, 1, 0, 2};
    int mm[4] = '{1, 2, 0, 1};
    int dv[4] = '{1, 2, 8, 4};
    for (int s = 0; s < 4; s++)
    begin
      prog(8'(s), 8'(nn[s]), 8'(mm[s]), 8'h00);
      rd_reg(pri_reg);
      check(v, 8'(mm[s]));
      rd_reg(`SOURCE_SELECT_REG);
      check(v, 8'(s));
      wr_reg(osc_reg, 8'h01);
      wait_pulse();
      check(width, (nn[s] + 1) * (mm[s] + 1) * dv[s]);
      cycles(3);
      check(irq_cnt - ib, 1);
      rd_reg(osc_reg);
      check(v[`ONESHOT_ACTIVE_FLAG], 1'b0);
    end
  endtask

  task automatic t_retrig();
    prog(8'h00, 8'h00, 8'h13, 8'h00);
    wr_reg(`SECONDARY_COUNT_REG, 8'h03);
    wr_reg(osc_reg, 8'h01);
    cycles(4);
    rd_reg(osc_reg);
    check(v[`ONESHOT_ACTIVE_FLAG], 1'b1);
    rd_reg(tc_reg);
    check(v, 8'h03);
    wr_reg(osc_reg, 8'h01);
    wait_pulse();
    check(width, 20);
    cycles(30);
    check(pulse_cnt - base, 1);
    rd_reg(`SECONDARY_COUNT_REG);
    check(v, 8'h03);
    wr_reg(tc_reg, 8'h00);
    base = pulse_cnt;
    wr_reg(osc_reg, 8'h01);
    wr_reg(tc_reg, 8'h01);
    cycles(20);
    check(pulse_cnt - base, 0);
  endtask

  task automatic t_stop();
    logic [3:0] sa[3] = '{osc_reg, tc_reg, tc_reg};
    logic [7:0] sd[3] = '{8'h02, 8'h00, 8'h04};
    for (int k = 0; k < 3; k++)
    begin
      prog(8'h00, 8'h00, 8'h31, 8'h00);
      wr_reg(osc_reg, 8'h01);
      cycles(10);
      wr_reg(sa[k], sd[k]);
      wait_pulse();
      check(width < 16, 1'b1);
      cycles(3);
      check(irq_cnt - ib, 0);
      rd_reg(pri_reg);
      check(v, 8'h31);
      rd_reg(tc_reg);
      check(v, k == 0 ? 8'h01 : 8'h00);
    end
  endtask

  task automatic t_live();
    prog(8'h02, 8'h00, 8'h09, 8'h00);
    wr_reg(osc_reg, 8'h01);
    cycles(30);
    rd_reg(pri_reg);
    check(v < 8'h09, 1'b1);
    wr_reg(pri_reg, 8'h03);
    wait_pulse();
    check(width, 80);
    base = pulse_cnt;
    wr_reg(osc_reg, 8'h01);
    wait_pulse();
    check(width, 32);
  endtask

  task automatic pin_try(input logic [7:0] io);
    prog(8'h00, 8'h00, 8'h01, io);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    for (d = 0; d < 40 && pulse_out_pin === level; d++)
      @(posedge clk);
    cycles(20);
  endtask

  initial
  begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    fire = 1'b0;
    level = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    check(pulse_out_pin, 1'b0);
    rd_reg(pri_reg);
    check(v, `COUNT_RESET);
    rd_reg(4'hF);
    check(v, 8'h00);
    t_width();
    t_retrig();
    t_stop();
    t_live();
    pin_try(8'h00);
    check(d, 40);
    pin_try(8'h0C);
    check(d < 6 && width == 2, 1'b1);
    pin_try(8'h04);
    check(d > 6 && d < 40, 1'b1);
    level = 1'b1;
    prog(8'h00, 8'h01, 8'h01, 8'h01);
    check(pulse_out_pin, 1'b1);
    wr_reg(osc_reg, 8'h01);
    wait_pulse();
    check(width, 4);
    check(pulse_out_pin, 1'b1);
    rd_reg(`IO_CONTROL_REG);
    check(v, 8'h01);
    complete_run();
  end
endmodule

`default_nettype wire

// ==== verif/pulse_load.sv ====
// Far-side model: a trigger source on the pin and a load timing pulses.
// Assumes the timer's clock and an output that idles at the given level.
`timescale 1ns/100ps
`default_nettype none

module pulse_load (
  input wire logic clk,
  input wire logic fire,
  input wire logic level,
  input wire logic pulse_out_pin,
  output var logic ext_trigger_pin,
  output var int pulse_cnt,
  output var int width
);
  int hold = 0;
  int run = 0;

  // ------------------------------------------------------------------
  // Trigger source and load
  // ------------------------------------------------------------------
  // pin trigger edges
  // A long high phase keeps the rising and falling edges well apart.
  always @(posedge clk)
  begin
    hold <= fire ? 8 : (hold > 0 ? hold - 1 : 0);
    ext_trigger_pin <= fire || hold > 1;
  end

  always @(posedge clk)
  begin
    if (pulse_out_pin !== level)
      run <= run + 1;
    else if (run > 0)
    begin
      width <= run;
      pulse_cnt <= pulse_cnt + 1;
      run <= 0;
    end
  end

  initial
  begin
    ext_trigger_pin = 1'b0;
    pulse_cnt = 0;
    width = 0;
  end
endmodule

`default_nettype wire
